// [core/mskm_axil.sv]
// AXI4-Lite slave holding the control and status registers
`timescale 1ns/1ps
`default_nettype none
module mskm_axil (
	input  wire logic                        sys_clk,
	input  wire logic                        nrst,
	input  wire logic [mskm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [mskm_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	mskm_reg_if.regs                         rif
);
	logic                        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [mskm_pkg::ADDR_W-1:0] awa_q, awa_d;
	logic [31:0]                 wd_q, wd_d, rd_q, rd_d;
	logic [3:0]                  ws_q, ws_d;
	logic [1:0]                  br_q, br_d, rr_q, rr_d;
	logic [4:0]                  cd_q, cd_d;

	// Address and data taken in either order, response after both
	assign s_axi_awready = !aw_q && !bv_q;
	assign s_axi_wready  = !w_q && !bv_q;
	assign s_axi_arready = !rv_q;

	always_comb begin
		{aw_d, awa_d, w_d, wd_d, ws_d} = {aw_q, awa_q, w_q, wd_q, ws_q};
		{bv_d, br_d, rv_d, rd_d, rr_d, cd_d} = {bv_q, br_q, rv_q, rd_q, rr_q, cd_q};
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d  = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d  = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (aw_q && w_q) begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			bv_d = 1'b1;
			br_d = (awa_q == mskm_pkg::CTRL_OFS) ? mskm_pkg::RESP_OKAY : mskm_pkg::RESP_SLVERR;
			if (awa_q == mskm_pkg::CTRL_OFS && ws_q[0]) begin
				cd_d = wd_q[4:0];
			end
		end else if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		// Unmapped reads answer zero with an error response
		if (s_axi_arvalid && s_axi_arready) begin
			rv_d = 1'b1;
			rr_d = mskm_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				mskm_pkg::CTRL_OFS: rd_d = {27'h0000000, cd_q};
				mskm_pkg::STAT_OFS: rd_d = {21'h000000, rif.status};
				default: begin
					rd_d = 32'h00000000;
					rr_d = mskm_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			{aw_q, awa_q, w_q, wd_q, ws_q} <= '0;
			{bv_q, br_q, rv_q, rd_q, rr_q} <= '0;
			cd_q <= mskm_pkg::CD_NEED_RST;
		end else begin
			{aw_q, awa_q, w_q, wd_q, ws_q} <= {aw_d, awa_d, w_d, wd_d, ws_d};
			{bv_q, br_q, rv_q, rd_q, rr_q} <= {bv_d, br_d, rv_d, rd_d, rr_d};
			cd_q <= cd_d;
		end
	end

	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp  = br_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rdata  = rd_q;
	assign s_axi_rresp  = rr_q;
	assign rif.cd_need  = cd_q;
endmodule
`default_nettype wire

// [core/mskm_core.sv]
// Digital core of the full-duplex tone modem
`timescale 1ns/1ps
`default_nettype none
module mskm_core (
	input  wire logic                        sys_clk,
	input  wire logic                        nrst,
	input  wire logic                        ref_clk_i,
	input  wire logic                        ref_sel_i,
	input  wire logic                        rate_lo_i,
	input  wire logic                        rate_hi_i,
	input  wire logic                        tx_en_n_i,
	input  wire logic                        tx_data_i,
	input  wire logic                        rx_en_i,
	input  wire logic                        rx_sig_i,
	input  wire logic [mskm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [mskm_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic                             tx_sync_o,
	output logic [7:0]                       tx_sig_o,
	output logic                             tx_sig_oe,
	output logic                             rx_raw_o,
	output logic                             rx_clk_data_o,
	output logic                             rx_sync_o,
	output logic                             carrier_o
);
	localparam int             NPIN     = 8;
	localparam logic [NPIN-1:0] PIN_INIT = 8'h04;
	localparam int             AW       = mskm_pkg::ACC_W;
	localparam int             CW       = mskm_pkg::CNT_W;

	// ----------------------------------------
	// Pin synchronisers and register slave
	// ----------------------------------------
	logic [NPIN-1:0]     pin_s;
	logic                ref_s, ref_sel_s, tx_en_n_s, rate_lo_s, rate_hi_s;
	logic                tx_data_s, rx_en_s, rx_sig_s;
	mskm_reg_if          rif ();

	// Transmit enable idles high so reset leaves the transmitter asleep
	mskm_sync #(
		.W    (NPIN),
		.INIT (PIN_INIT)
	) u_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.d_i     ({rx_sig_i, rx_en_i, tx_data_i, rate_hi_i, rate_lo_i, tx_en_n_i, ref_sel_i, ref_clk_i}),
		.q_o     (pin_s)
	);
	assign {rx_sig_s, rx_en_s, tx_data_s, rate_hi_s, rate_lo_s, tx_en_n_s, ref_sel_s, ref_s} = pin_s;

	mskm_axil u_axil (
		.sys_clk       (sys_clk),
		.nrst          (nrst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.rif           (rif.regs)
	);

	// ----------------------------------------
	// Reference tick and rate decode
	// ----------------------------------------
	logic                 ref_q;
	logic                 tick;
	mskm_pkg::mskm_rate_e rate;
	mskm_pkg::mskm_cfg_s  cfg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= ref_s;
		end
	end
	assign tick = ref_s && !ref_q;

	// One reference rising edge drives every counter below
	always_comb begin
		rate = mskm_pkg::rate_decode(rate_lo_s, rate_hi_s, ref_sel_s);
		cfg  = mskm_pkg::cfg_of(rate, ref_sel_s);
	end

	// Parabolic half-wave, symmetric about mid scale
	function automatic logic [7:0] sine_of(input logic [7:0] s);
		logic [6:0]  x;
		logic [13:0] y;
		logic [17:0] a;
		x = (s < mskm_pkg::SINE_HALF) ? s[6:0] : 7'(s - mskm_pkg::SINE_HALF);
		y = 14'(x) * 14'(mskm_pkg::SINE_HALF[6:0] - x);
		a = (18'(y) * 18'(mskm_pkg::SINE_GAIN)) >> mskm_pkg::SINE_SHIFT;
		return (s < mskm_pkg::SINE_HALF) ? mskm_pkg::SINE_MID + a[7:0] : mskm_pkg::SINE_MID - a[7:0];
	endfunction

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	logic [AW-1:0] tx_acc_q, tx_acc_d;
	logic [AW:0]   acc_sum;
	logic [7:0]    tx_step_q, tx_step_d, tx_sig_q, tx_sig_d;
	logic [CW-1:0] tx_bcnt_q, tx_bcnt_d;
	logic          tx_sync_q, tx_sync_d, tx_bit_q, tx_bit_d, tx_oe_q, tx_oe_d;

	// Step advances when accumulator passes the reference rate
	always_comb begin
		{tx_acc_d, tx_step_d, tx_sig_d} = {tx_acc_q, tx_step_q, tx_sig_q};
		{tx_bcnt_d, tx_sync_d, tx_bit_d, tx_oe_d} = {tx_bcnt_q, tx_sync_q, tx_bit_q, tx_oe_q};
		acc_sum = {1'b0, tx_acc_q} + {1'b0, (tx_bit_q ? cfg.inc1 : cfg.inc0)};
		if (tx_en_n_s) begin
			tx_acc_d  = '0;
			tx_step_d = '0;
			tx_bcnt_d = '0;
			tx_sync_d = 1'b1;
			tx_bit_d  = tx_data_s;
			tx_sig_d  = mskm_pkg::SINE_MID;
			tx_oe_d   = 1'b0;
		end else if (tick) begin
			tx_oe_d = 1'b1;
			// Whole bits are whole half-cycles, so no phase jump
			if (acc_sum >= {1'b0, cfg.modulus}) begin
				tx_acc_d  = AW'(acc_sum - {1'b0, cfg.modulus});
				tx_step_d = (tx_step_q >= mskm_pkg::SINE_LAST) ? 8'h00 : tx_step_q + 8'h01;
			end else begin
				tx_acc_d = acc_sum[AW-1:0];
			end
			if (tx_bcnt_q >= cfg.bit_ticks - 1'b1) begin
				tx_bcnt_d = '0;
				tx_bit_d  = tx_data_s;
			end else begin
				tx_bcnt_d = tx_bcnt_q + 1'b1;
			end
			tx_sync_d = (tx_bcnt_d < (cfg.bit_ticks >> 1));
			tx_sig_d  = sine_of(tx_step_d);
		end
	end

	// Separate register group keeps powersave of each path apart
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			{tx_acc_q, tx_step_q, tx_bcnt_q, tx_bit_q, tx_oe_q} <= '0;
			tx_sync_q <= 1'b1;
			tx_sig_q  <= mskm_pkg::SINE_MID;
		end else begin
			{tx_acc_q, tx_step_q, tx_bcnt_q, tx_bit_q, tx_oe_q} <= {tx_acc_d, tx_step_d, tx_bcnt_d, tx_bit_d, tx_oe_d};
			tx_sync_q <= tx_sync_d;
			tx_sig_q  <= tx_sig_d;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	logic [CW-1:0] rx_hcnt_q, rx_hcnt_d, rx_pcnt_q, rx_pcnt_d;
	logic [4:0]    rx_vcnt_q, rx_vcnt_d;
	logic          rx_prev_q, rx_prev_d, rx_raw_q, rx_raw_d, cd_q, cd_d;
	logic          rx_sync_q, rx_sync_d, rx_cdat_q, rx_cdat_d;

	// Half-cycle length decides the tone; too short or long drops carrier
	always_comb begin
		{rx_hcnt_d, rx_pcnt_d, rx_vcnt_d, rx_prev_d} = {rx_hcnt_q, rx_pcnt_q, rx_vcnt_q, rx_prev_q};
		{rx_raw_d, cd_d, rx_sync_d, rx_cdat_d} = {rx_raw_q, cd_q, rx_sync_q, rx_cdat_q};
		if (!rx_en_s) begin
			{rx_hcnt_d, rx_pcnt_d, rx_vcnt_d, rx_prev_d} = '0;
			{rx_raw_d, cd_d, rx_sync_d} = '0;
			rx_cdat_d = 1'b0;
		end else if (tick) begin
			rx_prev_d = rx_sig_s;
			if (rx_sig_s != rx_prev_q) begin
				rx_hcnt_d = '0;
				if (rx_hcnt_q >= cfg.half_min && rx_hcnt_q <= cfg.half_max) begin
					rx_raw_d  = (rx_hcnt_q > cfg.half_thr);
					rx_vcnt_d = (&rx_vcnt_q) ? rx_vcnt_q : rx_vcnt_q + 1'b1;
				end else begin
					rx_vcnt_d = '0;
				end
			end else begin
				rx_hcnt_d = (&rx_hcnt_q) ? rx_hcnt_q : rx_hcnt_q + 1'b1;
				if (rx_hcnt_q > cfg.half_max) begin
					rx_vcnt_d = '0;
				end
			end
			cd_d = (rx_vcnt_d >= rif.cd_need);
			// Realign on each data edge, free-run otherwise
			if (rx_raw_d != rx_raw_q || rx_pcnt_q >= cfg.bit_ticks - 1'b1) begin
				rx_pcnt_d = '0;
			end else begin
				rx_pcnt_d = rx_pcnt_q + 1'b1;
			end
			rx_sync_d = (rx_pcnt_d >= (cfg.bit_ticks >> 1));
			if (rx_pcnt_d == (cfg.bit_ticks >> 1)) begin
				rx_cdat_d = rx_raw_d;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			{rx_hcnt_q, rx_pcnt_q, rx_vcnt_q, rx_prev_q} <= '0;
			{rx_raw_q, cd_q, rx_sync_q, rx_cdat_q} <= '0;
		end else begin
			{rx_hcnt_q, rx_pcnt_q, rx_vcnt_q, rx_prev_q} <= {rx_hcnt_d, rx_pcnt_d, rx_vcnt_d, rx_prev_d};
			{rx_raw_q, cd_q, rx_sync_q, rx_cdat_q} <= {rx_raw_d, cd_d, rx_sync_d, rx_cdat_d};
		end
	end

	// ----------------------------------------
	// Outputs and status
	// ----------------------------------------
	assign tx_sync_o     = tx_sync_q;
	assign tx_sig_o      = tx_sig_q;
	assign tx_sig_oe     = tx_oe_q;
	assign rx_raw_o      = rx_raw_q;
	assign rx_clk_data_o = rx_cdat_q;
	assign rx_sync_o     = rx_sync_q;
	assign carrier_o     = cd_q;
	assign rif.status    = {rate, 1'b0, rx_en_s, tx_oe_q, tx_sync_q, rx_sync_q, rx_cdat_q, rx_raw_q, cd_q};

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_tx_idle;
		tx_en_n_s [*2];
	endsequence

	sequence s_tx_run;
		tx_oe_q && $past(tx_oe_q);
	endsequence

	a_tx_powersave: assert property (s_tx_idle |-> tx_sync_o && !tx_sig_oe)
		else $error("transmitter not asleep with enable high");
	a_tx_enable: assert property ($fell(tx_en_n_s) |-> ##[1:120] (tx_sig_oe || tx_en_n_s))
		else $error("transmitter did not start");
	a_tx_zero_cross: assert property (s_tx_run and $changed(tx_bit_q)
		|-> tx_step_q == 8'h00 || tx_step_q == mskm_pkg::SINE_HALF)
		else $error("tone switched away from zero crossing");
	a_tx_bit_hold: assert property (s_tx_run and $changed(tx_bit_q) |-> tx_bcnt_q == '0 && $rose(tx_sync_q))
		else $error("transmit bit changed mid period");
	a_tx_strobe_fall: assert property (s_tx_run and $fell(tx_sync_q) |-> tx_bcnt_q == (cfg.bit_ticks >> 1))
		else $error("bit strobe fell off half period");
	a_tx_sine_level: assert property (s_tx_run and $changed(tx_step_q)
		|-> tx_step_q <= mskm_pkg::SINE_LAST && tx_sig_o == sine_of(tx_step_q))
		else $error("pseudo-sine step out of range");
	a_rx_powersave: assert property (!rx_en_s |=> !carrier_o && !rx_raw_o && !rx_sync_o)
		else $error("receiver outputs active while off");
	a_rx_retime_off: assert property (!rx_en_s [*2] |-> !rx_clk_data_o)
		else $error("retimed data not held low");
	a_rx_retime: assert property (rx_en_s && $past(rx_en_s) && $changed(rx_cdat_q) |-> $rose(rx_sync_q))
		else $error("retimed data moved off clock edge");
	a_rx_flywheel: assert property ($rose(rx_sync_q) |-> rx_pcnt_q == (cfg.bit_ticks >> 1))
		else $error("receive clock edge misplaced");
	a_rx_raw_edge: assert property (rx_en_s && $past(rx_en_s) && $changed(rx_raw_q)
		|-> $past(tick) && ($past(rx_sig_s) != $past(rx_prev_q)))
		else $error("raw data changed without crossing");
	a_rx_carrier: assert property (carrier_o && $stable(rif.cd_need) |-> rx_vcnt_q >= rif.cd_need)
		else $error("carrier flag without qualified tone");
	a_rate_top: assert property (rate == mskm_pkg::MSKM_R4800 |-> rate_hi_s && !rate_lo_s && ref_sel_s)
		else $error("top rate selected illegally");
	a_ref_select: assert property (cfg.modulus == AW'(ref_sel_s ? mskm_pkg::REF_HI_HZ : mskm_pkg::REF_LO_HZ))
		else $error("reference rate misread");
endmodule
`default_nettype wire

// [core/mskm_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mskm_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] q_q;
	logic [W-1:0] q_d;

	// Accept a level only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
		end
	end

	// First stage feeds only the second, nothing else looks at it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			q_q  <= INIT;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q  <= q_d;
		end
	end

	assign q_o = q_q;
endmodule
`default_nettype wire

// [shared/mskm_pkg.sv]
// Shared constants, types and decode functions of the tone modem core
package mskm_pkg;

	// ----------------------------------------
	// Reference, rates and tones
	// ----------------------------------------
	localparam int REF_LO_HZ = 1008000;
	localparam int REF_HI_HZ = 4032000;
	localparam int BR_1200   = 1200;
	localparam int BR_2400   = 2400;
	localparam int BR_4800   = 4800;
	localparam int F_1200    = 1200;
	localparam int F_1800    = 1800;
	localparam int F_2400    = 2400;
	localparam int F_4800    = 4800;
	localparam int TOL_LO    = 3;
	localparam int TOL_HI    = 5;
	localparam int TOL_DEN   = 4;
	localparam int ACC_W     = 22;
	localparam int CNT_W     = 12;

	// ----------------------------------------
	// Pseudo-sine synthesis
	// ----------------------------------------
	localparam int         SINE_STEPS = 140;
	localparam logic [7:0] SINE_LAST  = 8'h8B;
	localparam logic [7:0] SINE_HALF  = 8'h46;
	localparam logic [7:0] SINE_MID   = 8'h80;
	localparam int         SINE_GAIN  = 13;
	localparam int         SINE_SHIFT = 7;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int         ADDR_W      = 4;
	localparam logic [3:0] CTRL_OFS    = 4'h0;
	localparam logic [3:0] STAT_OFS    = 4'h4;
	localparam logic [4:0] CD_NEED_RST = 5'h08;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         STAT_W      = 11;

	typedef enum logic [2:0] {
		MSKM_R1200 = 3'b001,
		MSKM_R2400 = 3'b010,
		MSKM_R4800 = 3'b100
	} mskm_rate_e;

	typedef struct packed {
		logic [ACC_W-1:0] modulus;
		logic [ACC_W-1:0] inc1;
		logic [ACC_W-1:0] inc0;
		logic [CNT_W-1:0] bit_ticks;
		logic [CNT_W-1:0] half_thr;
		logic [CNT_W-1:0] half_min;
		logic [CNT_W-1:0] half_max;
	} mskm_cfg_s;

	// Both selects high is undefined; low-rate select wins
	function automatic mskm_rate_e rate_decode(input logic lo, input logic hi, input logic ref_hi);
		if (lo) begin
			return MSKM_R1200;
		end
		if (hi && ref_hi) begin
			return MSKM_R4800;
		end
		return MSKM_R2400;
	endfunction

	// Timing of one rate: counts in reference ticks, modulus in Hz, increments in sine steps per second
	function automatic mskm_cfg_s mk_cfg(input int fr, input int br, input int f1, input int f0);
		int        h1;
		int        h0;
		mskm_cfg_s c;
		h1          = fr / (2 * f1);
		h0          = fr / (2 * f0);
		c.modulus   = ACC_W'(fr);
		c.inc1      = ACC_W'(f1 * SINE_STEPS);
		c.inc0      = ACC_W'(f0 * SINE_STEPS);
		c.bit_ticks = CNT_W'(fr / br);
		c.half_thr  = CNT_W'((h1 + h0) / 2);
		c.half_min  = CNT_W'(h0 * TOL_LO / TOL_DEN);
		c.half_max  = CNT_W'(h1 * TOL_HI / TOL_DEN);
		return c;
	endfunction

	function automatic mskm_cfg_s cfg_of(input mskm_rate_e r, input logic ref_hi);
		mskm_cfg_s c;
		c = '0;
		unique case (r)
			MSKM_R1200: c = ref_hi ? mk_cfg(REF_HI_HZ, BR_1200, F_1200, F_1800)
			                       : mk_cfg(REF_LO_HZ, BR_1200, F_1200, F_1800);
			MSKM_R2400: c = ref_hi ? mk_cfg(REF_HI_HZ, BR_2400, F_1200, F_2400)
			                       : mk_cfg(REF_LO_HZ, BR_2400, F_1200, F_2400);
			MSKM_R4800: c = mk_cfg(REF_HI_HZ, BR_4800, F_2400, F_4800);
		endcase
		return c;
	endfunction

endpackage

// [shared/mskm_reg_if.sv]
// Control and status carried between the register slave and the modem core
`timescale 1ns/1ps
`default_nettype none
interface mskm_reg_if;
	logic [4:0]                cd_need;
	logic [mskm_pkg::STAT_W-1:0] status;
	modport regs (output cd_need, input status);
	modport core (input cd_need, output status);
endinterface
`default_nettype wire

// [tb/msk_modem_digital_core_tb.sv]
// Self-checking bench of the tone modem core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t value differs", $time); end end
`define WT(c) for (int w = 0; w < 30000 && !(c); w++) @(posedge sys_clk);
module msk_modem_digital_core_tb;
	localparam int TK = 8;
	// Carrier settle time: eight bit periods plus 2 ms of reference ticks, at 2400 bit/s
	localparam int CD_WAIT = (8 * mskm_pkg::REF_LO_HZ / mskm_pkg::BR_2400 + mskm_pkg::REF_LO_HZ / 500) * TK;
	logic        sys_clk = 0, nrst = 0, ref_sel = 0, rate_lo = 0, rate_hi = 0, tx_en_n = 1, rx_en = 0;
	logic        ref_clk, tx_data, tx_sync, oe, raw, rxd, rxs, cd;
	logic [7:0]  sig;
	logic [3:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          n_fail = 0, total_checks = 0, cnt;
	// Rows: reference select, low select, high select, expected one-hot rate
	logic [5:0]  row [6] = '{6'h11, 6'h02, 6'h2C, 6'h0A, 6'h39, 6'h22};
	// Strobe high half in ticks; zero skips the slow timing check
	int          hv [6] = '{mskm_pkg::REF_LO_HZ / mskm_pkg::BR_1200 / 2, 0,
	                        mskm_pkg::REF_HI_HZ / mskm_pkg::BR_4800 / 2, 0, 0, 0};

	initial forever #10 sys_clk = ~sys_clk;

	mskm_host #(.TK(TK)) host (.sys_clk(sys_clk), .tx_sync(tx_sync), .ref_clk(ref_clk), .tx_data(tx_data));

	// Receive path fed by our own transmitter through a comparator at mid scale
	mskm_core uut (.sys_clk(sys_clk), .nrst(nrst), .ref_clk_i(ref_clk), .ref_sel_i(ref_sel),
		.rate_lo_i(rate_lo), .rate_hi_i(rate_hi), .tx_en_n_i(tx_en_n), .tx_data_i(tx_data),
		.rx_en_i(rx_en), .rx_sig_i(sig[7]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_sync_o(tx_sync),
		.tx_sig_o(sig), .tx_sig_oe(oe), .rx_raw_o(raw), .rx_clk_data_o(rxd), .rx_sync_o(rxs),
		.carrier_o(cd));

	task automatic give_verdict;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Write: both channels offered together, each dropped once taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge sys_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) begin
				done = 1;
				bready <= 0;
				`CHK(bresp, er)
			end
		end
		`CHK(done, 1'b1)
	endtask

	task automatic axr(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
		logic done;
		done = 0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 0;
			if (rvalid) begin
				done = 1;
				d = rdata;
				rready <= 0;
				`CHK(rresp, er)
			end
		end
		`CHK(done, 1'b1)
	endtask

	// Hang guard, well past the expected length of the run
	initial begin
		repeat (95000) @(posedge sys_clk);
		n_fail++;
		give_verdict;
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1;
		repeat (10) @(posedge sys_clk);
		`CHK({tx_sync, oe, sig, rxd, cd}, {1'b1, 1'b0, 8'h80, 1'b0, 1'b0})
		axr(4'h0, 2'h0, rd);
		`CHK(rd, 32'h00000008)
		axr(4'hC, 2'h2, rd);
		axw(4'h8, 32'h00000001, 2'h2);
		// Short qualification so the carrier test stays affordable
		axw(4'h0, 32'h00000002, 2'h0);
		axr(4'h0, 2'h0, rd);
		`CHK(rd, 32'h00000002)
		tx_en_n <= 0;
		repeat (40) @(posedge sys_clk);
		`CHK(oe, 1'b1)
		// Rates move only while the transmitter sleeps, so each bit still starts on a zero crossing
		foreach (row[k]) begin
			{ref_sel, rate_lo, rate_hi} <= row[k][5:3];
			tx_en_n <= 1;
			repeat (20) @(posedge sys_clk);
			tx_en_n <= 0;
			axr(4'h4, 2'h0, rd);
			`CHK(rd[10:8], row[k][2:0])
			if (hv[k] != 0) begin
				`WT(!tx_sync) `WT(tx_sync)
				cnt = 0;
				while (tx_sync && cnt < 30000) begin
					@(posedge sys_clk);
					cnt++;
				end
				`CHK(cnt, hv[k] * TK)
			end
		end
		{ref_sel, rate_lo, rate_hi} <= 3'h0;
		tx_en_n <= 1;
		repeat (20) @(posedge sys_clk);
		tx_en_n <= 0;
		rx_en <= 1;
		// Carrier flag is not trusted until it has had time to settle
		repeat (CD_WAIT) @(posedge sys_clk);
		`CHK(cd, 1'b1)
		`WT(rxs) `CHK(rxs, 1'b1)
		rx_en <= 0;
		repeat (10) @(posedge sys_clk);
		`CHK({raw, rxd, rxs, cd, oe}, 5'h01)
		tx_en_n <= 1;
		repeat (10) @(posedge sys_clk);
		`CHK({tx_sync, oe}, 2'h2)
		give_verdict;
	end
endmodule
`default_nettype wire

// [tb/mskm_host.sv]
// Host controller model: reference clock and serial transmit bits
`timescale 1ns/1ps
`default_nettype none
module mskm_host #(
	parameter int TK = 8
) (
	input  wire logic sys_clk,
	input  wire logic tx_sync,
	output logic      ref_clk,
	output logic      tx_data
);
	int         div_q;
	logic       sync_q;
	logic [7:0] pat_q;
	initial begin
		div_q = 0;
		sync_q = 1'b1;
		pat_q = 8'hB4;
		ref_clk = 1'b0;
		tx_data = 1'b1;
	end
	// Free-running reference, scaled to a few system clocks a tick to keep runs short
	always @(posedge sys_clk) begin
		div_q <= (div_q == TK - 1) ? 0 : div_q + 1;
		ref_clk <= (div_q < TK / 2);
		sync_q <= tx_sync;
		// New bit on the strobe fall, half a bit away from its sampling rise
		if (sync_q && !tx_sync) begin
			pat_q <= {pat_q[6:0], pat_q[7]};
			tx_data <= pat_q[7];
		end
	end
endmodule
`default_nettype wire
